// *** rbb_pkg.sv ***
// Behaviour
// - two-bit agc select: off, wide range, default best sensitivity, not recommended
// - agc-corrected signal strength readable at 0x10, half decibel per count
// - peak detector decays one count per 1.67us times 2^N
// - afc offset limited to limit times fxtal over 2^(if+chf+10)
// - zero offset limit holds synthesizer at centre, afc disabled
// - frequency error readable at 0x11 as signed 8-bit value
// - frequency error magnitude never exceeds 16 times the offset limit
// - afc restarts whenever receiver enters continuous or polled receive from idle
// - fsk, continuous receive and hold bit set: freeze afc on preamble match
// - hold-on-sync has no effect with ask modulation
// - pdf bw bit: 0 gives 0.6 rate bandwidth, 1 full rate
// - filtered output compared to threshold onto data pin, held high in polled receive; fsk threshold zero
// - ask threshold adapts to signal strength by one of two methods
// - method bit 0 selects precharged lowpass, 1 adaptive peak
// - lowpass bw bit affects only the precharged lowpass method
// - peak decay field affects only the adaptive peak discharge time
// - peak time constant field used only by the adaptive peak method
package rbb_pkg;
  localparam logic [7:0] ADDR_DEMOD = 8'h00;
  localparam logic [7:0] ADDR_AGC = 8'h01;
  localparam logic [7:0] ADDR_IFCHF = 8'h02;
  localparam logic [7:0] ADDR_PDF = 8'h03;
  localparam logic [7:0] ADDR_PEAK = 8'h05;
  localparam logic [7:0] ADDR_METHOD = 8'h06;
  localparam logic [7:0] ADDR_AFC1 = 8'h07;
  localparam logic [7:0] ADDR_AFC2 = 8'h08;
  localparam logic [7:0] ADDR_LO0 = 8'h09;
  localparam logic [7:0] ADDR_LO1 = 8'h0A;
  localparam logic [7:0] ADDR_LO2 = 8'h0B;
  localparam logic [7:0] ADDR_SIGNAL_STRENGTH_READING = 8'h10;
  localparam logic [7:0] ADDR_FEI = 8'h11;
  // reset values
  localparam logic [7:0] RST_AGC = 8'h26;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // field positions
  localparam int DTC_LSB = 0;
  localparam int AGC_SEL_LSB = 0;
  localparam int AGC_TRIM_LSB = 2;
  localparam int SIGNAL_STRENGTH_READING_DECAY_TRIM_LSB = 6;
  localparam int IF_SEL_BIT = 0;
  localparam int CHF_LSB = 1;
  localparam int MOD_SEL_BIT = 4;
  localparam int RATE_FINE_LSB = 0;
  localparam int RATE_COARSE_LSB = 3;
  localparam int PDF_BW_BIT = 6;
  localparam int PEAK_TC_LSB = 0;
  localparam int PEAK_DECAY_LSB = 5;
  localparam int METHOD_BIT = 0;
  localparam int LP_BW_BIT = 1;
  localparam int AFC_LIMIT_LSB = 0;
  localparam int AFC_GAIN_LSB = 3;
  localparam int AFC_HOLD_BIT = 0;
  // timing
  localparam real CLK_PERIOD_NS = 10.0;
  localparam real SIGNAL_STRENGTH_READING_DECAY_US = 1.67;
  localparam int SIGNAL_STRENGTH_READING_DECAY_CYC = int'(SIGNAL_STRENGTH_READING_DECAY_US * 1000.0 / CLK_PERIOD_NS);
  localparam int AFC_FEI_PER_LIMIT = 16;
  localparam int AFC_WORD_SHIFT = 2;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_CONT = 2'b01,
    RX_POLL = 2'b10
  } rbb_rx_state_t;
  typedef enum logic [1:0] {
    AFC_OFF = 2'b00,
    AFC_TRACK = 2'b01,
    AFC_HOLD = 2'b10
  } rbb_afc_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rbb_reg_req_t;
  typedef struct packed {
    logic sample_valid;
    logic signed [7:0] demod;
    logic signed [7:0] freq_err;
    logic [7:0] signal_strength_reading_raw;
    logic preamble_match;
  } rbb_bb_in_t;
endpackage

// *** rbb_core.sv ***
`timescale 1ns/10ps
`default_nettype none
module rbb_core
  import rbb_pkg::*;
#(
  parameter logic [7:0] AGC_ATTACK_LVL = 8'hC0,
  parameter logic [7:0] AGC_STEP_CNT = 8'h3C
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire rbb_reg_req_t reg_req,
  output logic [7:0] reg_rdata_q,
  input wire rbb_rx_state_t rx_state,
  input wire rbb_bb_in_t bb_in,
  output logic data_pin_q,
  output logic [23:0] lo_freq_word_q,
  output logic [1:0] agc_gain_step_q
);
  // ==========================================================
  // configuration registers
  logic [7:0] demod_q, agc_q, ifchf_q, pdf_q, peak_q, method_q;
  logic [7:0] afc1_q, afc2_q;
  logic [23:0] lo_center_word_q;
  logic [7:0] signal_strength_reading_peak_q;
  logic signed [7:0] fei_q;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      demod_q <= RST_ZERO;
      agc_q <= RST_AGC;
      ifchf_q <= RST_ZERO;
      pdf_q <= RST_ZERO;
      peak_q <= RST_ZERO;
      method_q <= RST_ZERO;
      afc1_q <= RST_ZERO;
      afc2_q <= RST_ZERO;
      lo_center_word_q <= 24'h000000;
    end
    else if (reg_req.wr)
    begin
      case (reg_req.addr)
        ADDR_DEMOD: demod_q <= reg_req.wdata;
        ADDR_AGC: agc_q <= reg_req.wdata;
        ADDR_IFCHF: ifchf_q <= reg_req.wdata;
        ADDR_PDF: pdf_q <= reg_req.wdata;
        ADDR_PEAK: peak_q <= reg_req.wdata;
        ADDR_METHOD: method_q <= reg_req.wdata;
        ADDR_AFC1: afc1_q <= reg_req.wdata;
        ADDR_AFC2: afc2_q <= reg_req.wdata;
        ADDR_LO0: lo_center_word_q[7:0] <= reg_req.wdata;
        ADDR_LO1: lo_center_word_q[15:8] <= reg_req.wdata;
        ADDR_LO2: lo_center_word_q[23:16] <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  // read-back; readings have no side effect on read
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      reg_rdata_q <= 8'h00;
    else if (reg_req.rd)
    begin
      case (reg_req.addr)
        ADDR_DEMOD: reg_rdata_q <= demod_q;
        ADDR_AGC: reg_rdata_q <= agc_q;
        ADDR_IFCHF: reg_rdata_q <= ifchf_q;
        ADDR_PDF: reg_rdata_q <= pdf_q;
        ADDR_PEAK: reg_rdata_q <= peak_q;
        ADDR_METHOD: reg_rdata_q <= method_q;
        ADDR_AFC1: reg_rdata_q <= afc1_q;
        ADDR_AFC2: reg_rdata_q <= afc2_q;
        ADDR_LO0: reg_rdata_q <= lo_center_word_q[7:0];
        ADDR_LO1: reg_rdata_q <= lo_center_word_q[15:8];
        ADDR_LO2: reg_rdata_q <= lo_center_word_q[23:16];
        ADDR_SIGNAL_STRENGTH_READING: reg_rdata_q <= signal_strength_reading_peak_q;
        ADDR_FEI: reg_rdata_q <= fei_q;
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // field views
  logic [1:0] agc_operating_select;
  logic [3:0] agc_release_trim;
  logic [1:0] signal_strength_reading_decay_trim;
  logic [2:0] demod_time_control, channel_filter_select, afc_offset_limit;
  logic [2:0] pdf_rate_coarse;
  logic [1:0] afc_loop_gain, peak_thresh_decay;
  logic [4:0] peak_thresh_tc;
  logic if_sel, modulation_select, pdf_bw_select, ask_thresh_method;
  logic lowpass_thresh_bw, afc_hold_on_sync, rx_active;
  assign agc_operating_select = agc_q[AGC_SEL_LSB +: 2];
  assign agc_release_trim = agc_q[AGC_TRIM_LSB +: 4];
  assign signal_strength_reading_decay_trim = agc_q[SIGNAL_STRENGTH_READING_DECAY_TRIM_LSB +: 2];
  assign demod_time_control = demod_q[DTC_LSB +: 3];
  assign if_sel = ifchf_q[IF_SEL_BIT];
  assign channel_filter_select = ifchf_q[CHF_LSB +: 3];
  assign modulation_select = ifchf_q[MOD_SEL_BIT];
  assign pdf_rate_coarse = pdf_q[RATE_COARSE_LSB +: 3];
  assign pdf_bw_select = pdf_q[PDF_BW_BIT];
  assign peak_thresh_tc = peak_q[PEAK_TC_LSB +: 5];
  assign peak_thresh_decay = peak_q[PEAK_DECAY_LSB +: 2];
  assign ask_thresh_method = method_q[METHOD_BIT];
  assign lowpass_thresh_bw = method_q[LP_BW_BIT];
  assign afc_offset_limit = afc1_q[AFC_LIMIT_LSB +: 3];
  assign afc_loop_gain = afc1_q[AFC_GAIN_LSB +: 2];
  assign afc_hold_on_sync = afc2_q[AFC_HOLD_BIT];
  assign rx_active = (rx_state == RX_CONT) || (rx_state == RX_POLL);

  // ==========================================================
  // agc and signal strength
  logic [1:0] agc_max_step;
  logic [8:0] signal_strength_reading_corr;
  logic [4:0] decay_sum, decay_n;
  logic [31:0] decay_lim, decay_cnt_q;
  always_comb
  begin
    case (agc_operating_select)
      2'b00: agc_max_step = 2'd0;
      2'b01: agc_max_step = 2'd1;
      default: agc_max_step = 2'd2;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      agc_gain_step_q <= 2'd0;
    else if (agc_gain_step_q > agc_max_step)
      agc_gain_step_q <= agc_max_step;
    else if (bb_in.sample_valid)
    begin
      if (bb_in.signal_strength_reading_raw > AGC_ATTACK_LVL && agc_gain_step_q < agc_max_step)
        agc_gain_step_q <= agc_gain_step_q + 2'd1;
      else if (bb_in.signal_strength_reading_raw < {1'b0, agc_release_trim, 3'b000}
               && agc_gain_step_q != 2'd0)
        agc_gain_step_q <= agc_gain_step_q - 2'd1;
    end
  end

  assign signal_strength_reading_corr = {1'b0, bb_in.signal_strength_reading_raw}
                     + 9'(agc_gain_step_q * AGC_STEP_CNT);
  assign decay_sum = 5'(if_sel) + 5'(channel_filter_select)
                     + 5'(demod_time_control) + 5'(signal_strength_reading_decay_trim);
  assign decay_n = (decay_sum == 5'd0) ? 5'd0 : decay_sum - 5'd1;
  assign decay_lim = 32'(SIGNAL_STRENGTH_READING_DECAY_CYC) << decay_n;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      signal_strength_reading_peak_q <= 8'h00;
      decay_cnt_q <= 32'h00000000;
    end
    else if (bb_in.sample_valid && signal_strength_reading_corr >= {1'b0, signal_strength_reading_peak_q})
    begin
      signal_strength_reading_peak_q <= signal_strength_reading_corr[8] ? 8'hFF : signal_strength_reading_corr[7:0];
      decay_cnt_q <= 32'h00000000;
    end
    else if (decay_cnt_q >= decay_lim - 32'd1)
    begin
      if (signal_strength_reading_peak_q != 8'h00)
        signal_strength_reading_peak_q <= signal_strength_reading_peak_q - 8'h01;
      decay_cnt_q <= 32'h00000000;
    end
    else
      decay_cnt_q <= decay_cnt_q + 32'd1;
  end

  // ==========================================================
  // automatic frequency control
  rbb_afc_state_t afc_state_q;
  logic rx_active_q, afc_freeze;
  logic signed [9:0] fei_lim, fei_sum, fei_clamped;
  logic signed [23:0] lo_offset;
  logic [3:0] bw_k;
  assign afc_freeze = modulation_select && rx_state == RX_CONT
                      && afc_hold_on_sync && bb_in.preamble_match;
  assign fei_lim = 10'(AFC_FEI_PER_LIMIT) * $signed({7'd0, afc_offset_limit});
  assign fei_sum = (bb_in.sample_valid && afc_state_q == AFC_TRACK)
                   ? 10'(fei_q) + 10'(bb_in.freq_err >>> (2'd3 - afc_loop_gain))
                   : 10'(fei_q);
  always_comb
  begin
    if (fei_sum > fei_lim)
      fei_clamped = fei_lim;
    else if (fei_sum < -fei_lim)
      fei_clamped = -fei_lim;
    else
      fei_clamped = fei_sum;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      rx_active_q <= 1'b0;
    else
      rx_active_q <= rx_active;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      afc_state_q <= AFC_OFF;
    else if (!rx_active)
      afc_state_q <= AFC_OFF;
    else if (!rx_active_q)
      afc_state_q <= AFC_TRACK;
    else
    begin
      case (afc_state_q)
        AFC_OFF: afc_state_q <= AFC_TRACK;
        AFC_TRACK: if (afc_freeze) afc_state_q <= AFC_HOLD;
        AFC_HOLD: afc_state_q <= AFC_HOLD;
        default: afc_state_q <= AFC_OFF;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      fei_q <= 8'sh00;
    else if (!rx_active || !rx_active_q || afc_offset_limit == 3'd0)
      fei_q <= 8'sh00;
    else
      fei_q <= fei_clamped[7:0];
  end

  // synth word moves fei * 2^(2 - if - chf) from the centre
  assign bw_k = 4'(if_sel) + 4'(channel_filter_select);
  assign lo_offset = (24'(fei_q) <<< AFC_WORD_SHIFT) >>> bw_k;
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      lo_freq_word_q <= 24'h000000;
    else
      lo_freq_word_q <= lo_center_word_q + lo_offset;
  end

  // ==========================================================
  // post demodulation filter and decision threshold
  logic signed [15:0] pdf_acc_q, lp_acc_q, pdf_in;
  logic signed [16:0] pdf_diff, lp_diff;
  logic signed [7:0] pdf_y, lp_thr, hi_q, lo_q, thr;
  logic [3:0] pdf_sh, lp_sh;
  logic [11:0] pk_cnt_q, pk_lim;
  assign pdf_sh = 4'(pdf_rate_coarse) + (pdf_bw_select ? 4'd0 : 4'd1);
  assign lp_sh = pdf_sh + (lowpass_thresh_bw ? 4'd2 : 4'd3);
  assign pk_lim = 12'({7'd0, peak_thresh_tc} + 12'd1) << peak_thresh_decay;
  assign pdf_in = {bb_in.demod, 8'h00};
  assign pdf_diff = 17'(pdf_in) - 17'(pdf_acc_q);
  assign lp_diff = 17'(pdf_acc_q) - 17'(lp_acc_q);
  assign pdf_y = pdf_acc_q[15:8];
  assign lp_thr = lp_acc_q[15:8];
  always_comb
  begin
    if (modulation_select)
      thr = 8'sh00;
    else if (!ask_thresh_method)
      thr = lp_thr;
    else
      thr = 8'((10'(hi_q) + 10'(lo_q)) >>> 1);
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      pdf_acc_q <= 16'sh0000;
    else if (bb_in.sample_valid)
      pdf_acc_q <= pdf_acc_q + 16'(pdf_diff >>> pdf_sh);
  end

  // lowpass threshold precharged from the filter at receive entry
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      lp_acc_q <= 16'sh0000;
    else if (rx_active && !rx_active_q)
      lp_acc_q <= pdf_acc_q;
    else if (bb_in.sample_valid)
      lp_acc_q <= lp_acc_q + 16'(lp_diff >>> lp_sh);
  end

  // peak and valley track the filter and discharge toward each other
  always_ff @(posedge sys_clk)
  begin
    if (reset || (rx_active && !rx_active_q))
    begin
      hi_q <= 8'sh00;
      lo_q <= 8'sh00;
      pk_cnt_q <= 12'h000;
    end
    else if (bb_in.sample_valid)
    begin
      pk_cnt_q <= (pk_cnt_q >= pk_lim - 12'd1) ? 12'h000 : pk_cnt_q + 12'd1;
      if (pdf_y > hi_q)
        hi_q <= pdf_y;
      else if (pk_cnt_q >= pk_lim - 12'd1 && hi_q > lo_q)
        hi_q <= hi_q - 8'sh01;
      if (pdf_y < lo_q)
        lo_q <= pdf_y;
      else if (pk_cnt_q >= pk_lim - 12'd1 && lo_q < hi_q)
        lo_q <= lo_q + 8'sh01;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      data_pin_q <= 1'b0;
    else if (rx_state == RX_POLL)
      data_pin_q <= 1'b1;
    else if (bb_in.sample_valid)
      data_pin_q <= pdf_y > thr;
  end

  // ==========================================================
  // checks
  agc_off_a: assert property (@(posedge sys_clk) disable iff (reset)
    agc_operating_select == 2'b00 |=> agc_gain_step_q == 2'd0)
    else $error("agc step nonzero with agc off");
  signal_strength_reading_read_a: assert property (@(posedge sys_clk) disable iff (reset)
    reg_req.rd && reg_req.addr == ADDR_SIGNAL_STRENGTH_READING |=> reg_rdata_q == $past(signal_strength_reading_peak_q))
    else $error("signal strength read mismatch");
  fei_clamp_a: assert property (@(posedge sys_clk) disable iff (reset)
    1'b1 |=> 10'(fei_q) <= $past(fei_lim) && 10'(fei_q) >= -$past(fei_lim))
    else $error("frequency error beyond limit");
  afc_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
    afc_offset_limit == 3'd0 |=> fei_q == 8'sh00 ##1 lo_freq_word_q == $past(lo_center_word_q))
    else $error("afc active with zero limit");
  afc_start_a: assert property (@(posedge sys_clk) disable iff (reset)
    rx_active && !rx_active_q |=> afc_state_q == AFC_TRACK && fei_q == 8'sh00)
    else $error("afc not restarted on receive entry");
  afc_freeze_a: assert property (@(posedge sys_clk) disable iff (reset)
    afc_state_q == AFC_TRACK && afc_freeze && rx_active_q && rx_active
    |=> afc_state_q == AFC_HOLD)
    else $error("afc not frozen on preamble");
  ask_no_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    afc_state_q == AFC_TRACK && !modulation_select |=> afc_state_q != AFC_HOLD)
    else $error("afc froze in ask mode");
  fsk_decide_a: assert property (@(posedge sys_clk) disable iff (reset)
    modulation_select && bb_in.sample_valid && rx_state == RX_CONT
    |=> data_pin_q == ($past(pdf_y) > 8'sh00))
    else $error("fsk decision not against zero");
  cfg_keep_a: assert property (@(posedge sys_clk) disable iff (reset)
    !reg_req.wr |=> $stable(afc1_q) && $stable(method_q) && $stable(pdf_q))
    else $error("configuration changed without write");
endmodule
`default_nettype wire

// *** rbb_mcu_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module rbb_mcu_model
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic data_pin_q,
  output logic bit_q
);
  // ==========================================
  // host side: latch the decided data pin
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      bit_q <= 1'b0;
    else
      bit_q <= data_pin_q;
  end
endmodule
`default_nettype wire

// *** rbb_core_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module rbb_core_tb;
  import rbb_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  rbb_reg_req_t rq = '0;
  rbb_rx_state_t rx = RX_IDLE;
  rbb_bb_in_t bb = '0;
  logic [7:0] rdata;
  logic dpin;
  logic [23:0] lo;
  logic [1:0] gs;
  logic mbit;
  int miscompares = 0;
  int cmp_count = 0;
  logic [7:0] ra [7] = '{ADDR_PDF, ADDR_PEAK, ADDR_METHOD, ADDR_AFC1,
    ADDR_AFC2, ADDR_SIGNAL_STRENGTH_READING, ADDR_FEI};
  logic [7:0] wv [5] = '{8'h42, 8'h74, 8'h03, 8'h1C, 8'h01};
  logic [1:0] gx [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
  always #5 sys_clk = ~sys_clk;
  rbb_core dut (.sys_clk(sys_clk), .reset(reset), .reg_req(rq),
    .reg_rdata_q(rdata), .rx_state(rx), .bb_in(bb), .data_pin_q(dpin),
    .lo_freq_word_q(lo), .agc_gain_step_q(gs));
  rbb_mcu_model mcu (.sys_clk(sys_clk), .reset(reset), .data_pin_q(dpin),
    .bit_q(mbit));
  // ==========================================
  // access tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    rq <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk);
    rq <= '0;
  endtask
  task automatic rdq(input logic [7:0] a);
    @(posedge sys_clk);
    rq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk);
    rq <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rdq(a);
    chk({16'h0000, rdata}, {16'h0000, e});
  endtask
  task automatic smp(input logic [7:0] f, input logic [7:0] d,
    input logic [7:0] r, input logic p, input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      bb <= '{1'b1, d, f, r, p};
    end
    @(posedge sys_clk);
    bb <= '0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic st(input rbb_rx_state_t s);
    @(posedge sys_clk);
    rx <= s;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic summarize;
    $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================
  // watchdog
  initial
  begin
    #(60000 * 10);
    miscompares++;
    summarize();
  end
  // ==========================================
  // tests
  initial
  begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    rd(ADDR_AGC, RST_AGC);
    foreach (ra[i]) rd(ra[i], RST_ZERO);
    for (int i = 0; i < 5; i++)
    begin
      wr(ra[i], wv[i]);
      rd(ra[i], wv[i]);
    end
    wr(ADDR_SIGNAL_STRENGTH_READING, 8'hFF);
    wr(ADDR_FEI, 8'hFF);
    rd(ADDR_SIGNAL_STRENGTH_READING, 8'h00);
    rd(ADDR_FEI, 8'h00);
    rd(8'h0C, 8'h00);
    $display("test registers done");
    wr(ADDR_IFCHF, 8'h00);
    wr(ADDR_LO0, 8'h56);
    wr(ADDR_LO1, 8'h34);
    wr(ADDR_LO2, 8'h12);
    wr(ADDR_AFC1, 8'h18);
    st(RX_CONT);
    smp(8'h00, 8'h00, 8'h40, 1'b0, 2);
    rd(ADDR_SIGNAL_STRENGTH_READING, 8'h40);
    repeat (748) @(posedge sys_clk);
    rdq(ADDR_SIGNAL_STRENGTH_READING);
    chk(rdata inside {8'h3B, 8'h3C}, 1'b1);
    $display("test strength done");
    smp(8'h7F, 8'h00, 8'h00, 1'b0, 4);
    rd(ADDR_FEI, 8'h00);
    chk(lo, 24'h123456);
    wr(ADDR_AFC1, 8'h19);
    smp(8'h7F, 8'h00, 8'h00, 1'b0, 4);
    rd(ADDR_FEI, 8'h10);
    chk(lo, 24'h123496);
    wr(ADDR_AFC1, 8'h1F);
    smp(8'h80, 8'h00, 8'h00, 1'b0, 4);
    rd(ADDR_FEI, 8'h90);
    chk(lo, 24'h123296);
    wr(ADDR_IFCHF, 8'h03);
    smp(8'h00, 8'h00, 8'h00, 1'b0, 1);
    chk(lo, 24'h1233E6);
    wr(ADDR_IFCHF, 8'h00);
    st(RX_IDLE);
    rd(ADDR_FEI, 8'h00);
    st(RX_POLL);
    chk(dpin, 1'b1);
    smp(8'h10, 8'h00, 8'h00, 1'b0, 1);
    rd(ADDR_FEI, 8'h10);
    $display("test afc done");
    wr(ADDR_AFC1, 8'h17);
    wr(ADDR_AFC2, 8'h01);
    for (int m = 1; m >= 0; m--)
    begin
      st(RX_IDLE);
      wr(ADDR_IFCHF, {3'h0, m[0], 4'h0});
      st(RX_CONT);
      smp(8'h40, 8'h00, 8'h00, 1'b0, 1);
      smp(8'h00, 8'h00, 8'h00, 1'b1, 1);
      smp(8'h40, 8'h00, 8'h00, 1'b0, 1);
      rd(ADDR_FEI, m[0] ? 8'h20 : 8'h40);
    end
    $display("test freeze done");
    wr(ADDR_IFCHF, 8'h10);
    smp(8'h00, 8'h64, 8'h00, 1'b0, 24);
    chk(mbit, 1'b1);
    smp(8'h00, 8'h9C, 8'h00, 1'b0, 24);
    chk(mbit, 1'b0);
    wr(ADDR_IFCHF, 8'h00);
    for (int m = 0; m < 2; m++)
    begin
      wr(ADDR_METHOD, {7'h00, m[0]});
      smp(8'h00, 8'h64, 8'h00, 1'b0, 24);
      chk(dpin, 1'b1);
      smp(8'h00, 8'h00, 8'h00, 1'b0, 24);
      chk(dpin, 1'b0);
    end
    $display("test data done");
    for (int m = 0; m < 4; m++)
    begin
      wr(ADDR_AGC, {2'h0, 4'h9, m[1:0]});
      smp(8'h00, 8'h00, 8'h10, 1'b0, 8);
      smp(8'h00, 8'h00, 8'hD0, 1'b0, 8);
      chk(gs, gx[m]);
    end
    $display("test agc done");
    summarize();
  end
endmodule
`default_nettype wire
